/* design/sbpc_pkg.sv */
// Purpose: Constants shared by the six-input bridge PWM control block.
// Assumes: One 50 MHz clock; registers are reached over Avalon-MM.
// Notes: Byte offsets are word aligned; windows are counted in clock cycles.
//
// Summary of operation
// - Bridge 2 decodes input pair: none, low only, high only, both high gives off.
// - Bridge 3 uses the same decode; equal inputs keep both switches off.
// - Turn-on drops the freewheel switch first; post-charge follows control selection.
// - High rise after freewheel window, before timeout: hard-off low side, high on.
// - High rise inside the freewheel window is ignored until freewheel window ends.
// - Active switch turn-off completes before the freewheel switch is activated.
// - Low rise inside the active window is ignored; low stays off until it ends.
// - Without role detection, bridge mode 10 makes the high side active.
// - With role detection, active and freewheel roles come from detection.
// - Each bridge has a delay-regulated flag, valid for control selection 10 or 11.
// - Regulated when on and off counters both reach at least 8.
// - Each PWM cycle the on counter counts up on match, down otherwise.
// - Each PWM cycle the off counter counts up on match, down otherwise.
// - Regulated also when the error sign flips three times in a row.
// - Charge and initial precharge currents use 6-bit codes, 64 steps.
// - Bridge mode 00 keeps both switches off by passive discharge.
// - Bridge mode 11 actively holds both switches off.
package sbpc_pkg;
  localparam int NB = 3;
  // Register byte offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TIMING = 8'h04;
  localparam logic [7:0] OFS_CURRENT = 8'h08;
  localparam logic [7:0] OFS_TARGET0 = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h24;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h28;
  // Control field positions.
  localparam int CTL_INSEL = 0;
  localparam int CTL_EN = 1;
  localparam int CTL_ROLE = 4;
  localparam int CTL_GCS = 5;
  localparam int CTL_PCDIS = 7;
  localparam int CTL_MODE = 8;
  // Reset values.
  localparam logic [31:0] RST_CTRL = 32'h0000_0000;
  localparam logic [23:0] RST_TIMING = 24'h40_10_10;
  localparam logic [13:0] RST_CURRENT = 14'h0000;
  localparam logic [15:0] RST_TARGET = 16'h0000;
  // Bridge modes and gate control selections.
  localparam logic [1:0] MODE_PASSIVE = 2'h0;
  localparam logic [1:0] MODE_LS_ACT = 2'h1;
  localparam logic [1:0] MODE_HS_ACT = 2'h2;
  localparam logic [1:0] MODE_HOLD = 2'h3;
  localparam logic [1:0] GCS_01 = 2'h1;
  localparam logic [1:0] GCS_10 = 2'h2;
  // Regulation thresholds.
  localparam logic [3:0] REG_CNT_MIN = 4'h8;
  localparam logic [3:0] REG_CNT_MAX = 4'hF;
  localparam logic [1:0] SIGN_FLIPS = 2'h3;
  typedef enum logic [1:0] {SB_IDLE, SB_HS_ON, SB_LS_ON, SB_GAP} sbpc_state_e;
endpackage : sbpc_pkg

/* design/sbpc_top.sv */
// Purpose: Gate control for three half-bridges driven by six PWM inputs.
// Assumes: PWM pins are asynchronous; delay measurements arrive on the local clock.
// Notes: Window and timeout lengths are register fields in clock cycles.
`timescale 1ns/100ps
module sbpc_top
  import sbpc_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] avm_address_in,
  input wire logic avm_read_in,
  input wire logic avm_write_in,
  input wire logic [31:0] avm_writedata_in,
  output logic [31:0] avm_readdata_out,
  output logic avm_waitrequest_out,
  input wire logic [5:0] pwm_in,
  input wire logic [2:0] meas_valid_in,
  input wire logic [23:0] measured_on_delay_in,
  input wire logic [23:0] measured_off_delay_in,
  output logic [2:0] high_side_switch_out,
  output logic [2:0] low_side_switch_out,
  output logic [2:0] active_hold_off_out,
  output logic [2:0] hard_off_current_out,
  output logic [2:0] postcharge_out,
  output logic [2:0] delay_regulated_flag_out,
  output logic [5:0] charge_current_code_out,
  output logic [5:0] initial_precharge_code_out,
  output logic irq_out
);

  // ---------------------------------------------------------------
  // Registers and helpers
  // ---------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [23:0] timing_r;
  logic [13:0] current_r;
  logic [15:0] target_r [NB];
  logic [5:0] irq_stat_r;
  logic [5:0] irq_mask_r;
  logic wait_r;
  logic [5:0] s1_r, s2_r, s3_r, pwm_q_r, pwm_d_r;
  sbpc_state_e st_r [NB];
  logic [7:0] gap_cnt_r [NB];
  logic gap_from_act_r [NB];
  logic gap_to_hs_r [NB];
  logic hs_active_r [NB];
  logic [3:0] on_cnt_r [NB];
  logic [3:0] off_cnt_r [NB];
  logic [1:0] flip_cnt_r [NB];
  logic last_sign_r [NB];
  logic [2:0] reg_r;
  logic [2:0] ign_evt;
  logic [2:0] reg_rise;

  // Saturating step of a regulation counter.
  function automatic logic [3:0] sat_step(input logic [3:0] v, input logic up);
    logic [3:0] r;
    r = v;
    if (up && v != REG_CNT_MAX)
    begin
      r = v + 4'h1;
    end
    else if (!up && v != 4'h0)
    begin
      r = v - 4'h1;
    end
    return r;
  endfunction : sat_step

  // Sign of a delay error: one when measured is below target.
  function automatic logic err_neg(input logic [7:0] m, input logic [7:0] t);
    return m < t;
  endfunction : err_neg

  wire bus_req = avm_read_in | avm_write_in;
  wire bus_wr = avm_write_in & ~wait_r;
  wire [7:0] win_act = timing_r[7:0];
  wire [7:0] win_fw = timing_r[15:8];
  wire [7:0] fw_tmo = timing_r[23:16];
  wire [1:0] gcs = ctrl_r[CTL_GCS +: 2];

  // ---------------------------------------------------------------
  // Avalon-MM slave
  // ---------------------------------------------------------------
  // Waitrequest drops one cycle after a request is seen.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      wait_r <= 1'b1;
    end
    else if (bus_req && wait_r)
    begin
      wait_r <= 1'b0;
    end
    else
    begin
      wait_r <= 1'b1;
    end
  end

  // Read data is captured while waitrequest is still high.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      avm_readdata_out <= 32'h0000_0000;
    end
    else if (avm_read_in && wait_r)
    begin
      if (avm_address_in == OFS_CTRL)
      begin
        avm_readdata_out <= ctrl_r;
      end
      else if (avm_address_in == OFS_TIMING)
      begin
        avm_readdata_out <= {8'h00, timing_r};
      end
      else if (avm_address_in == OFS_CURRENT)
      begin
        avm_readdata_out <= {18'h00000, current_r};
      end
      else if (avm_address_in >= OFS_TARGET0 && avm_address_in < OFS_TARGET0 + 8'h0C)
      begin
        avm_readdata_out <= {16'h0000, target_r[avm_address_in[3:2]]};
      end
      else if (avm_address_in == OFS_STATUS)
      begin
        avm_readdata_out <= {29'h0, delay_regulated_flag_out};
      end
      else if (avm_address_in == OFS_IRQ_STAT)
      begin
        avm_readdata_out <= {26'h0, irq_stat_r};
      end
      else if (avm_address_in == OFS_IRQ_MASK)
      begin
        avm_readdata_out <= {26'h0, irq_mask_r};
      end
      else
      begin
        avm_readdata_out <= 32'h0000_0000;
      end
    end
  end

  // Configuration writes take effect when waitrequest is low.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl_r <= RST_CTRL;
      timing_r <= RST_TIMING;
      current_r <= RST_CURRENT;
      irq_mask_r <= 6'h00;
      for (int i = 0; i < NB; i++)
      begin
        target_r[i] <= RST_TARGET;
      end
    end
    else if (bus_wr)
    begin
      if (avm_address_in == OFS_CTRL)
      begin
        ctrl_r <= {18'h0, avm_writedata_in[13:0]};
      end
      else if (avm_address_in == OFS_TIMING)
      begin
        timing_r <= avm_writedata_in[23:0];
      end
      else if (avm_address_in == OFS_CURRENT)
      begin
        current_r <= {avm_writedata_in[13:8], 2'h0, avm_writedata_in[5:0]} & 14'h3F3F;
      end
      else if (avm_address_in >= OFS_TARGET0 && avm_address_in < OFS_TARGET0 + 8'h0C)
      begin
        target_r[avm_address_in[3:2]] <= avm_writedata_in[15:0];
      end
      else if (avm_address_in == OFS_IRQ_MASK)
      begin
        irq_mask_r <= avm_writedata_in[5:0];
      end
    end
  end

  // Sticky events; a new event wins over a write-one clear.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      irq_stat_r <= 6'h00;
      irq_out <= 1'b0;
    end
    else
    begin
      irq_stat_r <= (irq_stat_r & ~((bus_wr && avm_address_in == OFS_IRQ_STAT) ?
                    avm_writedata_in[5:0] : 6'h00)) | {ign_evt, reg_rise};
      irq_out <= |(irq_stat_r & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // PWM input synchroniser
  // ---------------------------------------------------------------
  // Three stages; a level is accepted once stages two and three agree.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      s1_r <= 6'h00;
      s2_r <= 6'h00;
      s3_r <= 6'h00;
      pwm_q_r <= 6'h00;
      pwm_d_r <= 6'h00;
    end
    else
    begin
      s1_r <= pwm_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      pwm_q_r <= (s2_r & s3_r) | (pwm_q_r & (s2_r | s3_r));
      pwm_d_r <= pwm_q_r;
    end
  end

  // ---------------------------------------------------------------
  // Per-bridge switch sequencing
  // ---------------------------------------------------------------
  for (genvar b = 0; b < NB; b++)
  begin : g_br
    wire [1:0] mode = ctrl_r[CTL_MODE + 2 * b +: 2];
    wire run = ctrl_r[CTL_INSEL] & ctrl_r[CTL_EN + b] &
               (mode == MODE_LS_ACT || mode == MODE_HS_ACT);
    wire req_hs = run & pwm_q_r[2 * b] & ~pwm_q_r[2 * b + 1];
    wire req_ls = run & pwm_q_r[2 * b + 1] & ~pwm_q_r[2 * b];
    wire [7:0] win = gap_from_act_r[b] ? win_act : win_fw;
    wire tgt_req = gap_to_hs_r[b] ? req_hs : req_ls;
    wire want_on = (st_r[b] == SB_GAP) && tgt_req && gap_cnt_r[b] >= win;
    wire tgt_rise = gap_to_hs_r[b] ? (pwm_q_r[2 * b] & ~pwm_d_r[2 * b]) :
                    (pwm_q_r[2 * b + 1] & ~pwm_d_r[2 * b + 1]);
    assign ign_evt[b] = (st_r[b] == SB_GAP) && gap_cnt_r[b] < win && tgt_rise;

    // Role of each switch, fixed by mode or taken from detection.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
      if (!arst_n_in)
      begin
        hs_active_r[b] <= 1'b0;
      end
      else if (!ctrl_r[CTL_ROLE])
      begin
        hs_active_r[b] <= (mode == MODE_HS_ACT);
      end
      else if (st_r[b] == SB_IDLE && (req_hs || req_ls))
      begin
        hs_active_r[b] <= req_hs;
      end
    end

    // Sequencer: the switch going off finishes its window before the other starts.
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
      if (!arst_n_in)
      begin
        st_r[b] <= SB_IDLE;
        gap_cnt_r[b] <= 8'h00;
        gap_from_act_r[b] <= 1'b0;
        gap_to_hs_r[b] <= 1'b0;
        high_side_switch_out[b] <= 1'b0;
        low_side_switch_out[b] <= 1'b0;
        hard_off_current_out[b] <= 1'b0;
        active_hold_off_out[b] <= 1'b0;
        postcharge_out[b] <= 1'b0;
      end
      else
      begin
        active_hold_off_out[b] <= ctrl_r[CTL_INSEL] && mode == MODE_HOLD;
        hard_off_current_out[b] <= 1'b0;
        postcharge_out[b] <= !ctrl_r[CTL_PCDIS] && (gcs == GCS_01 || gcs == GCS_10) &&
                             (high_side_switch_out[b] ? hs_active_r[b] :
                              low_side_switch_out[b] && !hs_active_r[b]);
        if (gap_cnt_r[b] != 8'hFF)
        begin
          gap_cnt_r[b] <= gap_cnt_r[b] + 8'h01;
        end
        case (st_r[b])
          SB_IDLE:
          begin
            if (req_hs)
            begin
              st_r[b] <= SB_HS_ON;
              high_side_switch_out[b] <= 1'b1;
            end
            else if (req_ls)
            begin
              st_r[b] <= SB_LS_ON;
              low_side_switch_out[b] <= 1'b1;
            end
          end
          SB_HS_ON, SB_LS_ON:
          begin
            if ((st_r[b] == SB_HS_ON) ? !req_hs : !req_ls)
            begin
              // Switch off first, then open the cross-conduction window.
              st_r[b] <= SB_GAP;
              gap_cnt_r[b] <= 8'h00;
              gap_from_act_r[b] <= (st_r[b] == SB_HS_ON) == hs_active_r[b];
              gap_to_hs_r[b] <= (st_r[b] == SB_LS_ON);
              high_side_switch_out[b] <= 1'b0;
              low_side_switch_out[b] <= 1'b0;
            end
          end
          default:
          begin
            if (!run)
            begin
              st_r[b] <= SB_IDLE;
            end
            else if (want_on)
            begin
              // Late turn-on after a freewheel gap, inside the timeout, pulses hard-off in the same cycle as turn-on.
              st_r[b] <= gap_to_hs_r[b] ? SB_HS_ON : SB_LS_ON;
              high_side_switch_out[b] <= gap_to_hs_r[b];
              low_side_switch_out[b] <= !gap_to_hs_r[b];
              hard_off_current_out[b] <= !gap_from_act_r[b] && gap_cnt_r[b] < fw_tmo;
            end
            else if (!req_hs && !req_ls && gap_cnt_r[b] >= win)
            begin
              st_r[b] <= SB_IDLE;
            end
          end
        endcase
      end
    end

    // Delay regulation counters and sign tracking.
    wire [7:0] m_on = measured_on_delay_in[8 * b +: 8];
    wire [7:0] m_off = measured_off_delay_in[8 * b +: 8];
    wire on_eq = m_on == target_r[b][7:0];
    wire off_eq = m_off == target_r[b][15:8];
    wire sgn = err_neg(m_on, target_r[b][7:0]) | err_neg(m_off, target_r[b][15:8]);
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
      if (!arst_n_in)
      begin
        on_cnt_r[b] <= 4'h0;
        off_cnt_r[b] <= 4'h0;
        flip_cnt_r[b] <= 2'h0;
        last_sign_r[b] <= 1'b0;
      end
      else if (meas_valid_in[b])
      begin
        on_cnt_r[b] <= sat_step(on_cnt_r[b], on_eq);
        off_cnt_r[b] <= sat_step(off_cnt_r[b], off_eq);
        last_sign_r[b] <= sgn;
        if (on_eq && off_eq)
        begin
          flip_cnt_r[b] <= 2'h0;
        end
        else if (sgn != last_sign_r[b] && flip_cnt_r[b] != SIGN_FLIPS)
        begin
          flip_cnt_r[b] <= flip_cnt_r[b] + 2'h1;
        end
        else if (sgn == last_sign_r[b])
        begin
          flip_cnt_r[b] <= 2'h0;
        end
      end
    end
    assign reg_rise[b] = reg_r[b] & ~delay_regulated_flag_out[b];
  end

  // Regulation flag, meaningful for selection 10 or 11 only.
  always_comb
  begin
    for (int i = 0; i < NB; i++)
    begin
      reg_r[i] = gcs[1] && ((on_cnt_r[i] >= REG_CNT_MIN && off_cnt_r[i] >= REG_CNT_MIN) ||
                 flip_cnt_r[i] == SIGN_FLIPS);
    end
  end

  // Registered flags and gate current codes.
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      delay_regulated_flag_out <= 3'h0;
      charge_current_code_out <= 6'h00;
      initial_precharge_code_out <= 6'h00;
    end
    else
    begin
      delay_regulated_flag_out <= reg_r;
      charge_current_code_out <= current_r[5:0];
      initial_precharge_code_out <= current_r[13:8];
    end
  end

  assign avm_waitrequest_out = wait_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_NO_SHOOT: assert property (!(high_side_switch_out[1] && low_side_switch_out[1]))
    else $error("Bridge 2 both switches on.");
  AST_BOTH_HIGH_OFF: assert property (pwm_q_r[5:4] == 2'h3 [*3] |-> !high_side_switch_out[2])
    else $error("Bridge 3 high side on with both inputs high.");
  AST_PASSIVE: assert property (ctrl_r[9:8] == MODE_PASSIVE [*2] |-> !high_side_switch_out[0]
    && !low_side_switch_out[0])
    else $error("Passive mode switch on.");
  AST_HOLD: assert property (ctrl_r[CTL_INSEL] && ctrl_r[9:8] == MODE_HOLD |=>
    active_hold_off_out[0])
    else $error("Hold mode not asserted.");
  AST_GAP_HS: assert property ($fell(low_side_switch_out[0]) |-> !high_side_switch_out[0])
    else $error("High side on while low side still on.");
  AST_WINDOW: assert property (st_r[0] == SB_GAP && gap_cnt_r[0] < g_br[0].win |=>
    !high_side_switch_out[0] && !low_side_switch_out[0])
    else $error("Switch on inside window.");
  AST_ROLE: assert property (!ctrl_r[CTL_ROLE] && ctrl_r[9:8] == MODE_HS_ACT |=>
    hs_active_r[0])
    else $error("High side not active by default.");
  AST_CNT_UP: assert property (meas_valid_in[0] && g_br[0].on_eq && on_cnt_r[0] != REG_CNT_MAX
    |=> on_cnt_r[0] == $past(on_cnt_r[0]) + 4'h1)
    else $error("On counter did not count up.");
  AST_CNT_FLOOR: assert property (meas_valid_in[0] && !g_br[0].off_eq && off_cnt_r[0] == 4'h0
    |=> off_cnt_r[0] == 4'h0)
    else $error("Off counter wrapped.");
  AST_REG_FLAG: assert property (gcs == GCS_10 && on_cnt_r[0] >= REG_CNT_MIN &&
    off_cnt_r[0] >= REG_CNT_MIN |=> delay_regulated_flag_out[0])
    else $error("Regulation flag missing.");
  AST_CODE: assert property (##1 charge_current_code_out == $past(current_r[5:0]))
    else $error("Charge code not applied.");
  COV_HANDOVER: cover property (st_r[0] == SB_GAP ##[1:300] high_side_switch_out[0]);
  COV_HARD_OFF: cover property (hard_off_current_out[0]);
  COV_REG: cover property ($rose(delay_regulated_flag_out[0]));

endmodule : sbpc_top

/* testbench/sbpc_mcu_model.sv */
// Purpose: Microcontroller model for the PWM pins and delay reports.
// Assumes: The bench calls its tasks; every change follows a rising clock edge.
// Notes: The gap argument lets a test report promptly or slowly.
`timescale 1ns/100ps
module sbpc_mcu_model
(
  input wire logic clk_in,
  output logic [5:0] pwm_out,
  output logic [2:0] meas_valid_out,
  output logic [23:0] on_delay_out,
  output logic [23:0] off_delay_out
);
  // --------------------------------------------------------------
  // Pin state
  // --------------------------------------------------------------
  // All pins start low so every bridge sees both inputs off.
  initial
  begin
    pwm_out = 6'h00;
    meas_valid_out = 3'h0;
    on_delay_out = 24'h000000;
    off_delay_out = 24'h000000;
  end

  // Sets both inputs of one bridge after an edge.
  task automatic drive(input int b, input logic hs, input logic ls);
    @(posedge clk_in);
    pwm_out[2*b] <= hs;
    pwm_out[2*b+1] <= ls;
  endtask : drive

  // Reports one PWM cycle of delays; the data goes stale after the pulse.
  task automatic measure(input int b, input logic [7:0] on_d, input logic [7:0] off_d,
                         input int gap);
    @(posedge clk_in);
    on_delay_out[8*b+:8] <= on_d;
    off_delay_out[8*b+:8] <= off_d;
    meas_valid_out[b] <= 1'b1;
    @(posedge clk_in);
    meas_valid_out[b] <= 1'b0;
    on_delay_out[8*b+:8] <= ~on_d;
    off_delay_out[8*b+:8] <= ~off_d;
    repeat (gap) @(posedge clk_in);
  endtask : measure
endmodule : sbpc_mcu_model

/* testbench/tb_six_input_bridge_pwm_control.sv */
// Purpose: Self-checking bench for the six-input bridge PWM control block.
// Assumes: Default window lengths of 16 cycles.
// Notes: Each scenario drives the block and judges its outputs itself.
`timescale 1ns/100ps
module tb_six_input_bridge_pwm_control
  import sbpc_pkg::*;
;
  logic clk_in;
  logic arst_n_in;
  logic [7:0] bus_addr;
  logic bus_rd;
  logic bus_wr;
  logic [31:0] bus_wdata;
  logic [31:0] avm_readdata_out;
  logic avm_waitrequest_out;
  logic [5:0] pwm;
  logic [2:0] meas_valid;
  logic [23:0] on_dly;
  logic [23:0] off_dly;
  logic [2:0] high_side_switch_out;
  logic [2:0] low_side_switch_out;
  logic [2:0] active_hold_off_out;
  logic [2:0] postcharge_out;
  logic [2:0] delay_regulated_flag_out;
  logic [5:0] charge_current_code_out;
  logic [5:0] initial_precharge_code_out;
  logic irq_out;
  logic [2:0] hard_off;
  int num_errors = 0;
  int check_count = 0;
  int hard_off_cnt = 0;

  // --------------------------------------------------------------
  // Instances and clock
  // --------------------------------------------------------------
  sbpc_top u_dut (.clk_in(clk_in), .arst_n_in(arst_n_in), .avm_address_in(bus_addr),
    .avm_read_in(bus_rd), .avm_write_in(bus_wr), .avm_writedata_in(bus_wdata),
    .avm_readdata_out(avm_readdata_out), .avm_waitrequest_out(avm_waitrequest_out),
    .pwm_in(pwm), .meas_valid_in(meas_valid), .measured_on_delay_in(on_dly),
    .measured_off_delay_in(off_dly), .high_side_switch_out(high_side_switch_out),
    .low_side_switch_out(low_side_switch_out), .active_hold_off_out(active_hold_off_out),
    .hard_off_current_out(hard_off), .postcharge_out(postcharge_out),
    .delay_regulated_flag_out(delay_regulated_flag_out),
    .charge_current_code_out(charge_current_code_out),
    .initial_precharge_code_out(initial_precharge_code_out), .irq_out(irq_out));
  sbpc_mcu_model u_mcu (.clk_in(clk_in), .pwm_out(pwm), .meas_valid_out(meas_valid),
    .on_delay_out(on_dly), .off_delay_out(off_dly));

  // A 20 ns clock.
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Counts hard-off pulses of bridge 2.
  always @(posedge clk_in)
    hard_off_cnt <= hard_off_cnt + int'(hard_off[1]);

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  // Compares one value.
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Prints the verdict and ends the run.
  task automatic tally_and_finish();
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish

  // One bus transfer, held until waitrequest is seen low at a rising edge.
  task automatic bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
                          output logic [31:0] q);
    int n = 0;
    @(posedge clk_in);
    bus_addr <= a;
    bus_wr <= wr;
    bus_rd <= ~wr;
    bus_wdata <= d;
    do
    begin
      @(posedge clk_in);
      n++;
    end while (avm_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50)
      chk("bus_answer", 32'h1, 32'h0);
    q = avm_readdata_out;
    bus_rd <= 1'b0;
    bus_wr <= 1'b0;
  endtask : bus_xfer

  // Writes one register.
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(a, 1'b1, d, q);
  endtask : wr_reg

  // Reads one register and compares it.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(a, 1'b0, 32'h0, q);
    chk(what, q, exp);
  endtask : rd_chk

  // Lets n edges pass, then moves to a settled sampling point.
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask : settle

  // Control word: input select, all bridges enabled, one mode.
  function automatic logic [31:0] ctrl_word(input logic [1:0] mode, input logic [1:0] gcs);
    return {18'h0, mode, mode, mode, 1'b0, gcs, 5'h0F};
  endfunction : ctrl_word

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Reset values, a read-only status write and an unmapped address.
  task automatic t_reset();
    rd_chk("ctrl", 8'h00, 32'h0000_0000);
    rd_chk("timing", 8'h04, 32'h0040_1010);
    rd_chk("current", 8'h08, 32'h0000_0000);
    wr_reg(8'h20, 32'h0000_0007);
    rd_chk("status", 8'h20, 32'h0000_0000);
    rd_chk("unmapped", 8'h3C, 32'h0000_0000);
    chk("hs_reset", high_side_switch_out, 32'h0);
  endtask : t_reset

  // Walks all input pairs of bridges 2 and 3 in one mode.
  task automatic t_decode(input logic [1:0] mode);
    logic [1:0] p;
    wr_reg(8'h00, ctrl_word(mode, 2'h1));
    for (int i = 0; i < 4; i++)
    begin
      p = i[1:0];
      u_mcu.drive(1, p[1], p[0]);
      u_mcu.drive(2, p[1], p[0]);
      settle(60);
      chk("hs_b2", high_side_switch_out[1], p == 2'b10);
      chk("ls_b2", low_side_switch_out[1], p == 2'b01);
      chk("hs_b3", high_side_switch_out[2], p == 2'b10);
      chk("ls_b3", low_side_switch_out[2], p == 2'b01);
    end
    u_mcu.drive(1, 1'b0, 1'b0);
    u_mcu.drive(2, 1'b0, 1'b0);
    chk("hard_off_b2", hard_off_cnt, 32'h1);
  endtask : t_decode

  // Modes 00 and 11 keep both switches off whatever the inputs say.
  task automatic t_off_modes();
    u_mcu.drive(0, 1'b1, 1'b0);
    u_mcu.drive(1, 1'b0, 1'b1);
    wr_reg(8'h00, ctrl_word(2'b00, 2'h1));
    settle(40);
    chk("hs_m00", high_side_switch_out, 32'h0);
    chk("ls_m00", low_side_switch_out, 32'h0);
    chk("hold_m00", active_hold_off_out, 32'h0);
    wr_reg(8'h00, ctrl_word(2'b11, 2'h1));
    settle(40);
    chk("hs_m11", high_side_switch_out, 32'h0);
    chk("ls_m11", low_side_switch_out, 32'h0);
    chk("hold_m11", active_hold_off_out, 32'h7);
    u_mcu.drive(0, 1'b0, 1'b0);
    u_mcu.drive(1, 1'b0, 1'b0);
  endtask : t_off_modes

  // A low-side rise inside the active window waits, and is flagged.
  task automatic t_window();
    wr_reg(8'h00, ctrl_word(2'b10, 2'h1));
    u_mcu.drive(0, 1'b1, 1'b0);
    settle(40);
    chk("hs_on", high_side_switch_out[0], 32'h1);
    chk("postcharge", postcharge_out[0], 32'h1);
    wr_reg(8'h24, 32'h0000_003F);
    wr_reg(8'h28, 32'h0000_0008);
    u_mcu.drive(0, 1'b0, 1'b0);
    u_mcu.drive(0, 1'b0, 1'b1);
    settle(8);
    chk("hs_off_first", high_side_switch_out[0], 32'h0);
    chk("ls_held", low_side_switch_out[0], 32'h0);
    settle(30);
    chk("ls_late", low_side_switch_out[0], 32'h1);
    rd_chk("ignored_bit", 8'h24, 32'h0000_0008);
    chk("irq_set", irq_out, 32'h1);
    wr_reg(8'h24, 32'h0000_0008);
    settle(3);
    chk("irq_clear", irq_out, 32'h0);
    u_mcu.drive(0, 1'b0, 1'b0);
  endtask : t_window

  // Feeds n delay reports to bridge 1 and lets the flag settle.
  task automatic meas_n(input int n, input logic [7:0] on_d, input logic [7:0] off_d);
    for (int i = 0; i < n; i++)
      u_mcu.measure(0, on_d, off_d, (i % 2) * 4);
    settle(3);
  endtask : meas_n

  // Counter threshold, saturation at zero and the sign-flip path.
  task automatic t_regulate();
    wr_reg(8'h00, ctrl_word(2'b10, 2'h2));
    wr_reg(8'h10, 32'h0000_0605);
    wr_reg(8'h24, 32'h0000_003F);
    wr_reg(8'h28, 32'h0000_0001);
    meas_n(7, 8'h05, 8'h06);
    chk("flag_7", delay_regulated_flag_out[0], 32'h0);
    meas_n(1, 8'h05, 8'h06);
    chk("flag_8", delay_regulated_flag_out[0], 32'h1);
    rd_chk("status_8", 8'h20, 32'h0000_0001);
    chk("irq_reg", irq_out, 32'h1);
    meas_n(1, 8'h05, 8'h09);
    chk("flag_off_miss", delay_regulated_flag_out[0], 32'h0);
    meas_n(20, 8'h09, 8'h09);
    meas_n(1, 8'h01, 8'h06);
    meas_n(1, 8'h09, 8'h09);
    meas_n(1, 8'h01, 8'h06);
    chk("flag_flips", delay_regulated_flag_out[0], 32'h1);
    meas_n(20, 8'h09, 8'h09);
    meas_n(7, 8'h05, 8'h06);
    chk("flag_sat_7", delay_regulated_flag_out[0], 32'h0);
    meas_n(1, 8'h05, 8'h06);
    chk("flag_sat_8", delay_regulated_flag_out[0], 32'h1);
    wr_reg(8'h24, 32'h0000_0001);
    settle(3);
    chk("irq_reg_clear", irq_out, 32'h0);
  endtask : t_regulate

  // Both code ends of the charge and precharge currents.
  task automatic t_current();
    wr_reg(8'h08, 32'h0000_003F);
    settle(2);
    chk("charge_max", charge_current_code_out, 32'h3F);
    chk("pre_min", initial_precharge_code_out, 32'h00);
    wr_reg(8'h08, 32'h0000_3F00);
    settle(2);
    chk("charge_min", charge_current_code_out, 32'h00);
    chk("pre_max", initial_precharge_code_out, 32'h3F);
    rd_chk("current_rb", 8'h08, 32'h0000_3F00);
  endtask : t_current

  // --------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------
  // Reset for 20 cycles, then run every scenario.
  initial
  begin
    arst_n_in = 1'b0;
    bus_addr = 8'h00;
    bus_rd = 1'b0;
    bus_wr = 1'b0;
    bus_wdata = 32'h0;
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    t_reset();
    t_decode(2'b10);
    t_decode(2'b01);
    t_off_modes();
    t_window();
    t_regulate();
    t_current();
    tally_and_finish();
  end

  // Cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    tally_and_finish();
  end
endmodule : tb_six_input_bridge_pwm_control
